// ---- core/pbad_core.sv ----
// peripheral base register bank, window decode and chip-select gating
//
// Summary of operation
// - no peripheral access until base written
// - base and control registers always at fixed addresses
// - config registers reset only by reset plus halt
// - chip selects off on config register locations
// - internal access output flags on-chip accesses
// - 8-bit bus needs low base byte written
// - conflict sets flag; bus error only when enabled
// - base register is 16-bit read-write
// - base reads bfff after total reset
// - base register only in supervisor data space
// - bits 15..13 give window function code
// - internal access beats every chip select
`default_nettype none
module pbad_core (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // reset pins, low when asserted
    input  wire logic        reset_pin_n,
    input  wire logic        halt_pin_n,
    // bus width strap, high for 8-bit operation
    input  wire logic        bus_8bit,
    // bus access
    input  wire logic        bus_strobe,
    input  wire logic        bus_read,
    input  wire logic        upper_strobe,
    input  wire logic        lower_strobe,
    input  wire logic [23:0] bus_addr,
    input  wire logic [2:0]  bus_fc,
    // data bus, split into three signals
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe,
    // answer to the master
    output logic             int_ack,
    // another device answered the current access
    input  wire logic        ext_answer,
    // chip-select requests in, gated lines out (active low)
    input  wire logic [3:0]  cs_request,
    output logic      [3:0]  cs_n,
    // decode outputs
    output logic             internal_access_indicator,
    output logic             periph_select,
    output logic             bus_error_signal,
    // register contents for the rest of the chip
    output logic      [15:0] peripheral_base,
    output logic      [15:0] clock_control
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // word match on a fixed location, byte bit ignored
    function automatic logic word_at(input logic [23:0] a, input logic [23:0] loc);
        word_at = (a[23:1] == loc[23:1]);
    endfunction

    // merge a byte-laned write into a register value
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic hi, input logic lo);
        merge = old;
        if (hi) begin
            merge[15:8] = wd[15:8];
        end
        if (lo) begin
            merge[7:0] = wd[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    pbad_pkg::pbad_state_t state_q, state_d;   // access sequencer
    logic [15:0] base_q, base_d;               // peripheral base register
    logic [15:0] sysctl_q, sysctl_d;           // system control register
    logic [15:0] clkctl_q, clkctl_d;           // clock control register
    logic        valid_q, valid_d;             // base has been written
    logic [15:0] rdata_q, rdata_d;             // read data holder
    logic        oe_q, oe_d;                   // driving the data bus
    logic        ack_q, ack_d;                 // one-cycle answer
    logic        bus_error_signal_q, bus_error_signal_d;               // bus error level
    logic        total_reset;                  // reset and halt together
    logic        start;                        // first cycle of an access
    logic        sup_data;                     // supervisor data space
    logic        hit_base;                     // base register selected
    logic        hit_sysctl;                   // system control selected
    logic        hit_clkctl;                   // clock control selected
    logic        cfg_loc;                      // any config location, any space
    logic        reg_sel;                      // a register answers here
    logic        window_hit;                   // inside relocated window
    logic        internal;                     // any on-chip target
    logic        wr_base;                      // write strobe to base register
    logic [3:0]  cs_pick;                      // priority-resolved requests

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // window compare lives in its own small module
    pbad_match u_match (
        .bus_addr   (bus_addr),
        .bus_fc     (bus_fc),
        .base_value (base_q),
        .base_valid (valid_q),
        .window_hit (window_hit)
    );

    // fixed locations never depend on the programmed base
    always_comb begin
        total_reset = !reset_pin_n && !halt_pin_n;
        start       = bus_strobe && (state_q == pbad_pkg::ST_IDLE);
        sup_data    = (bus_fc == pbad_pkg::FC_SUP_DATA);
        hit_base    = word_at(bus_addr, pbad_pkg::ADDR_BASE) && sup_data;
        hit_sysctl  = word_at(bus_addr, pbad_pkg::ADDR_SYSCTL) && sup_data;
        hit_clkctl  = word_at(bus_addr, pbad_pkg::ADDR_CLKCTL) && sup_data;
        // chip-select suppression applies in every function-code space
        cfg_loc     = word_at(bus_addr, pbad_pkg::ADDR_BASE)
                   || word_at(bus_addr, pbad_pkg::ADDR_SYSCTL)
                   || word_at(bus_addr, pbad_pkg::ADDR_CLKCTL);
        reg_sel     = hit_base || hit_sysctl || hit_clkctl;
        internal    = reg_sel || window_hit;
        wr_base     = start && !bus_read && hit_base;
    end

    ////////////////////////////////////////////////////////////////////////////
    // chip-select gating

    // lowest index wins, so at most one line is driven
    genvar gi;
    generate
        for (gi = 0; gi < pbad_pkg::CS_N; gi++) begin : g_cs
            if (gi == 0) begin : g_top
                assign cs_pick[gi] = cs_request[gi];
            end else begin : g_rest
                assign cs_pick[gi] = cs_request[gi] && !(|cs_request[gi-1:0]);
            end
        end
    endgenerate

    // on-chip targets outrank every chip select
    always_comb begin
        if (bus_strobe && (internal || cfg_loc)) begin
            cs_n = 4'hf;
        end else begin
            cs_n = ~cs_pick;
        end
        // external decode may use this to keep off the bus
        internal_access_indicator = bus_strobe && internal;
        // steer on-chip memory and peripherals, not the registers here
        periph_select = bus_strobe && window_hit && !reg_sel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, next values

    always_comb begin
        base_d   = base_q;
        sysctl_d = sysctl_q;
        clkctl_d = clkctl_q;
        valid_d  = valid_q;
        if (total_reset) begin
            // only the combined reset clears these
            base_d   = pbad_pkg::BASE_RESET;
            sysctl_d = pbad_pkg::SYSCTL_RST;
            clkctl_d = pbad_pkg::CLKCTL_RST;
            valid_d  = 1'b0;
        end else begin
            if (wr_base) begin
                // full sixteen bits, byte by byte as the strobes say
                base_d = merge(base_q, data_in, upper_strobe, lower_strobe);
                // narrow bus writes high then low, so wait for the low byte
                if (bus_8bit) begin
                    valid_d = valid_q || lower_strobe;
                end else begin
                    valid_d = valid_q || upper_strobe || lower_strobe;
                end
            end
            if (start && !bus_read && hit_clkctl) begin
                clkctl_d = merge(clkctl_q, data_in, upper_strobe, lower_strobe);
            end
            if (start && !bus_read && hit_sysctl) begin
                sysctl_d = merge(sysctl_q, data_in, upper_strobe, lower_strobe);
                // the flag clears by writing a one and ignores a written one otherwise
                sysctl_d[pbad_pkg::CONFLICT_BIT] = sysctl_q[pbad_pkg::CONFLICT_BIT]
                    && !(lower_strobe && data_in[pbad_pkg::CONFLICT_BIT]);
            end
            // a conflict in the same cycle as the clear still lands
            if (bus_strobe && window_hit && ext_answer) begin
                sysctl_d[pbad_pkg::CONFLICT_BIT] = 1'b1;
            end
        end
    end

    // power-on constants; later resets go through the combined reset path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            base_q   <= pbad_pkg::BASE_RESET;
            sysctl_q <= pbad_pkg::SYSCTL_RST;
            clkctl_q <= pbad_pkg::CLKCTL_RST;
            valid_q  <= 1'b0;
        end else begin
            base_q   <= base_d;
            sysctl_q <= sysctl_d;
            clkctl_q <= clkctl_d;
            valid_q  <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer and answer, next values

    // one answer per strobe; the master must drop the strobe before the next
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        oe_d    = oe_q;
        ack_d   = 1'b0;
        bus_error_signal_d  = bus_error_signal_q;
        case (state_q)
            pbad_pkg::ST_IDLE: begin
                if (bus_strobe) begin
                    state_d = pbad_pkg::ST_HOLD;
                    if (reg_sel) begin
                        ack_d = 1'b1;
                        oe_d  = bus_read;
                        // both lanes return the whole register, whatever the strobes say
                        if (hit_base) begin
                            rdata_d = base_q;
                        end else if (hit_sysctl) begin
                            rdata_d = sysctl_q;
                        end else begin
                            rdata_d = clkctl_q;
                        end
                    end
                end
            end
            pbad_pkg::ST_HOLD: begin
                if (!bus_strobe) begin
                    // access over: release the bus
                    state_d = pbad_pkg::ST_IDLE;
                    oe_d    = 1'b0;
                    bus_error_signal_d  = 1'b0;
                end
            end
            default: begin
                state_d = pbad_pkg::ST_IDLE;
                oe_d    = 1'b0;
                bus_error_signal_d  = 1'b0;
            end
        endcase
        // error only when software allowed it, held to end of access
        if (bus_strobe && window_hit && ext_answer
            && sysctl_q[pbad_pkg::CONFLICT_EN]) begin
            bus_error_signal_d = 1'b1;
        end
        // a combined reset aborts whatever was in flight
        if (total_reset) begin
            state_d = pbad_pkg::ST_IDLE;
            oe_d    = 1'b0;
            ack_d   = 1'b0;
            bus_error_signal_d  = 1'b0;
        end
    end

    // sequencer flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pbad_pkg::ST_IDLE;
            rdata_q <= 16'h0000;
            oe_q    <= 1'b0;
            ack_q   <= 1'b0;
            bus_error_signal_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            oe_q    <= oe_d;
            ack_q   <= ack_d;
            bus_error_signal_q  <= bus_error_signal_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // data and status come straight from flops
    always_comb begin
        data_out         = rdata_q;
        data_oe          = oe_q;
        int_ack          = ack_q;
        bus_error_signal = bus_error_signal_q;
        peripheral_base  = base_q;
        clock_control    = clkctl_q;
    end

endmodule
`default_nettype wire

// ---- core/pbad_pkg.sv ----
// constants, field layout and state type for the peripheral base decode block
`default_nettype none
package pbad_pkg;
    // bus widths
    localparam int          ADDR_W      = 24;                // system address width
    localparam int          DATA_W      = 16;                // system data width
    localparam int          CS_N        = 4;                 // chip-select lines, 0 highest
    // fixed register locations (byte addresses, word aligned)
    localparam logic [23:0] ADDR_BASE   = 24'h0000f2;        // peripheral base register
    localparam logic [23:0] ADDR_SYSCTL = 24'h0000f4;        // system control register
    localparam logic [23:0] ADDR_CLKCTL = 24'h0000fa;        // clock control register
    // reset values
    localparam logic [15:0] BASE_RESET  = 16'hbfff;          // reads back, not yet valid
    localparam logic [15:0] SYSCTL_RST  = 16'h0000;
    localparam logic [15:0] CLKCTL_RST  = 16'h0000;
    // peripheral base register fields
    localparam int          FC_HI       = 15;                // function code field top
    localparam int          FC_LO       = 13;                // function code field bottom
    localparam int          CFC_BIT     = 12;                // compare function code enable
    localparam int          BASE_HI     = 11;                // base address bits 23..12
    localparam int          WIN_LO      = 12;                // lowest compared address bit
    // system control register fields
    localparam int          CONFLICT_BIT = 0;                // decode conflict flag, w1c
    localparam int          CONFLICT_EN  = 1;                // decode_conflict_enable
    // function codes
    localparam logic [2:0]  FC_SUP_DATA = 3'h5;              // supervisor data space
    // access sequencer states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_HOLD
    } pbad_state_t;
endpackage
`default_nettype wire

// ---- core/pbad_match.sv ----
// address and function-code comparator for the relocated peripheral window
`default_nettype none
module pbad_match (
    // bus side
    input  wire logic [23:0] bus_addr,
    input  wire logic [2:0]  bus_fc,
    // programmed base
    input  wire logic [15:0] base_value,
    input  wire logic        base_valid,
    // result
    output logic             window_hit
);
    logic addr_eq;  // upper address bits equal the base
    logic fc_ok;    // function code agrees, or is ignored

    ////////////////////////////////////////////////////////////////////////////
    // compare address bits 23..12 against base bits 11..0
    always_comb begin
        addr_eq = (bus_addr[pbad_pkg::ADDR_W-1:pbad_pkg::WIN_LO]
                   == base_value[pbad_pkg::BASE_HI:0]);
        // function code only counts when the compare bit is set
        if (base_value[pbad_pkg::CFC_BIT]) begin
            fc_ok = (bus_fc == base_value[pbad_pkg::FC_HI:pbad_pkg::FC_LO]);
        end else begin
            fc_ok = 1'b1;
        end
        // an unwritten base never matches
        window_hit = base_valid && addr_eq && fc_ok;
    end
endmodule
`default_nettype wire

// ---- verif/pbad_properties.sv ----
// checker properties for the peripheral base decode block
`default_nettype none
module pbad_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        reset_pin_n,
    input wire logic        halt_pin_n,
    // bus side
    input wire logic        bus_strobe,
    input wire logic        bus_read,
    input wire logic        upper_strobe,
    input wire logic        lower_strobe,
    input wire logic [23:0] bus_addr,
    input wire logic [2:0]  bus_fc,
    input wire logic [15:0] data_in,
    input wire logic        ext_answer,
    input wire logic [3:0]  cs_request,
    // design outputs
    input wire logic [15:0] data_out,
    input wire logic        data_oe,
    input wire logic        int_ack,
    input wire logic [3:0]  cs_n,
    input wire logic        internal_access_indicator,
    input wire logic        periph_select,
    input wire logic        bus_error_signal,
    input wire logic [15:0] peripheral_base
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [3:0] first_cs;  // lowest requested select wins
    logic       cfg_loc;   // any fixed configuration location
    logic       sup_base;  // base register in supervisor data
    assign first_cs = cs_request & (4'h0 - cs_request);
    assign cfg_loc  = bus_addr == 24'h0000f2 || bus_addr == 24'h0000f4 || bus_addr == 24'h0000fa;
    assign sup_base = bus_addr == 24'h0000f2 && bus_fc == 3'h5;
    // a strobe rising marks an access taken by an idle sequencer
    sequence start_s; $rose(bus_strobe); endsequence
    sequence base_wr_s;
        start_s ##0 sup_base && !bus_read && upper_strobe && lower_strobe;
    endsequence
    sequence base_rd_s; start_s ##0 sup_base && bus_read; endsequence
    cfg_no_cs_a: assert property (bus_strobe && cfg_loc |-> cs_n == 4'hf)
        else $error("chip select during config access");
    iac_no_cs_a: assert property (internal_access_indicator |-> cs_n == 4'hf)
        else $error("chip select during internal access");
    idle_cs_a: assert property (!bus_strobe |-> cs_n == ~first_cs)
        else $error("chip select priority wrong");
    base_seen_a: assert property (bus_strobe && sup_base |-> internal_access_indicator)
        else $error("internal access not flagged");
    psel_iac_a: assert property (periph_select |-> internal_access_indicator)
        else $error("window hit without internal access");
    base_store_a: assert property (base_wr_s |=> int_ack
        && peripheral_base == $past(data_in))
        else $error("base write not stored");
    base_read_a: assert property (base_rd_s |=> int_ack && data_oe
        && data_out == peripheral_base)
        else $error("base read wrong");
    user_refuse_a: assert property (start_s ##0 bus_addr == 24'h0000f2 && bus_fc != 3'h5
        |=> !int_ack && $stable(peripheral_base))
        else $error("base reached outside supervisor data");
    bus_error_signal_cause_a: assert property ($rose(bus_error_signal)
        |-> $past(periph_select) && $past(ext_answer))
        else $error("bus error without conflict");
    bus_error_signal_drop_a: assert property (!$past(bus_strobe) |-> !bus_error_signal)
        else $error("bus error outlives access");
    total_rst_a: assert property (!reset_pin_n && !halt_pin_n
        |=> peripheral_base == 16'hbfff)
        else $error("total reset missed base");
    pin_only_a: assert property (!reset_pin_n && halt_pin_n && !bus_strobe
        |=> $stable(peripheral_base))
        else $error("reset pin alone touched base");
endmodule
bind pbad_core pbad_checker u_pbad_checker (
    .clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .halt_pin_n(halt_pin_n),
    .bus_strobe(bus_strobe), .bus_read(bus_read), .upper_strobe(upper_strobe),
    .lower_strobe(lower_strobe), .bus_addr(bus_addr), .bus_fc(bus_fc), .data_in(data_in),
    .ext_answer(ext_answer), .cs_request(cs_request), .data_out(data_out), .data_oe(data_oe),
    .int_ack(int_ack), .cs_n(cs_n), .internal_access_indicator(internal_access_indicator),
    .periph_select(periph_select), .bus_error_signal(bus_error_signal),
    .peripheral_base(peripheral_base)
);
`default_nettype wire

// ---- verif/pbad_master.sv ----
// bus master model that launches accesses into the decode block
`default_nettype none
module pbad_master (
    // clock
    input  wire logic        clock,
    // bus requests
    output logic             bus_strobe,
    output logic             bus_read,
    output logic             upper_strobe,
    output logic             lower_strobe,
    output logic      [23:0] bus_addr,
    output logic      [2:0]  bus_fc,
    output logic      [15:0] data_in,
    // answers
    input  wire logic        int_ack,
    input  wire logic [15:0] data_out,
    input  wire logic [3:0]  cs_n,
    input  wire logic        periph_select,
    input  wire logic        bus_error_signal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        acked;      // answer seen
    logic [15:0] rdata;      // data taken at the answer
    logic        psel_seen;  // window decode at launch
    logic [3:0]  cs_seen;    // chip selects at launch
    logic        bus_error_signal_seen;  // bus error during access
    initial begin
        bus_strobe = 1'b0;
        bus_read = 1'b1;
        upper_strobe = 1'b0;
        lower_strobe = 1'b0;
        bus_addr = 24'h000000;
        bus_fc = 3'h0;
        data_in = 16'h0000;
    end
    // one access; callers never pass function code seven
    task automatic access(input logic [23:0] a, input logic [2:0] fc, input logic rd,
                          input logic [1:0] ln, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        bus_strobe <= 1'b1;
        bus_read <= rd;
        upper_strobe <= ln[1];
        lower_strobe <= ln[0];
        bus_addr <= a;
        bus_fc <= fc;
        data_in <= wd;
        #1;
        psel_seen = periph_select;
        cs_seen = cs_n;
        acked = 1'b0;
        bus_error_signal_seen = 1'b0;
        // held until answered or for at most three edges; window accesses get no answer here
        while (!acked && n < 3) begin
            @(posedge clock);
            acked = int_ack === 1'b1;
            rdata = data_out;
            bus_error_signal_seen = bus_error_signal_seen | (bus_error_signal === 1'b1);
            n++;
        end
        // released lines must not keep the last value
        bus_strobe <= 1'b0;
        upper_strobe <= 1'b0;
        lower_strobe <= 1'b0;
        data_in <= ~wd;
        bus_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the peripheral base decode block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;        // system clock
    logic        rst_n = 1'b0;        // power-on reset
    logic        reset_pin_n = 1'b1;  // reset pin
    logic        halt_pin_n = 1'b1;   // halt pin
    logic        bus_8bit = 1'b0;     // bus width strap
    logic        ext_answer = 1'b0;   // foreign device answers
    logic [3:0]  cs_request = 4'h6;   // selects 1 and 2 requested
    logic        bus_strobe, bus_read, upper_strobe, lower_strobe;
    logic [23:0] bus_addr;
    logic [2:0]  bus_fc;
    logic [15:0] data_in, data_out, peripheral_base, clock_control;
    logic        data_oe, int_ack, internal_access_indicator, periph_select, bus_error_signal;
    logic [3:0]  cs_n;
    int          errors = 0;
    int          checks = 0;
    always #2 clock = ~clock;
    pbad_core uut (
        .clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .halt_pin_n(halt_pin_n),
        .bus_8bit(bus_8bit), .bus_strobe(bus_strobe), .bus_read(bus_read),
        .upper_strobe(upper_strobe), .lower_strobe(lower_strobe), .bus_addr(bus_addr),
        .bus_fc(bus_fc), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .int_ack(int_ack), .ext_answer(ext_answer), .cs_request(cs_request), .cs_n(cs_n),
        .internal_access_indicator(internal_access_indicator), .periph_select(periph_select),
        .bus_error_signal(bus_error_signal), .peripheral_base(peripheral_base),
        .clock_control(clock_control));
    pbad_master host (
        .clock(clock), .bus_strobe(bus_strobe), .bus_read(bus_read),
        .upper_strobe(upper_strobe), .lower_strobe(lower_strobe), .bus_addr(bus_addr),
        .bus_fc(bus_fc), .data_in(data_in), .int_ack(int_ack), .data_out(data_out),
        .cs_n(cs_n), .periph_select(periph_select), .bus_error_signal(bus_error_signal));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // supervisor data write, answered
    task automatic wr(input logic [23:0] a, input logic [1:0] ln, input logic [15:0] d);
        host.access(a, 3'h5, 1'b0, ln, d);
        check("write_ack", {15'h0000, host.acked}, 16'h0001);
    endtask
    // supervisor data read with expected word
    task automatic rd(input logic [23:0] a, input logic [15:0] exp);
        host.access(a, 3'h5, 1'b1, 2'b11, 16'h0000);
        check("read_ack", {15'h0000, host.acked}, 16'h0001);
        check("read_data", host.rdata, exp);
    endtask
    // decode probe: window hit and chip selects at launch
    task automatic probe(input logic [23:0] a, input logic [2:0] fc, input logic hit,
                         input logic [3:0] csx);
        host.access(a, fc, 1'b1, 2'b11, 16'h0000);
        check("periph_select", {15'h0000, host.psel_seen}, {15'h0000, hit});
        check("cs_n", {12'h000, host.cs_seen}, {12'h000, csx});
    endtask
    // reset and halt pins driven to the given levels for two edges
    task automatic pins(input logic rp, input logic hp);
        @(posedge clock);
        reset_pin_n <= rp;
        halt_pin_n <= hp;
        repeat (2) @(posedge clock);
        reset_pin_n <= 1'b1;
        halt_pin_n <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #20000;
        errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check("base_port", peripheral_base, 16'hbfff);
        rd(24'h0000f2, 16'hbfff);
        probe(24'hfff010, 3'h5, 1'b0, 4'hd);
        wr(24'h0000f2, 2'b11, 16'ha123);
        check("base_port", peripheral_base, 16'ha123);
        rd(24'h0000f2, 16'ha123);
        probe(24'h123456, 3'h5, 1'b1, 4'hf);
        probe(24'h124000, 3'h5, 1'b0, 4'hd);
        probe(24'h123ffe, 3'h1, 1'b1, 4'hf);
        wr(24'h0000f2, 2'b11, 16'hb123);
        probe(24'h123456, 3'h1, 1'b0, 4'hd);
        probe(24'h123456, 3'h5, 1'b1, 4'hf);
        probe(24'h0000f4, 3'h1, 1'b0, 4'hf);
        probe(24'h0000fa, 3'h2, 1'b0, 4'hf);
        host.access(24'h0000f2, 3'h1, 1'b0, 2'b11, 16'h0000);
        check("user_ack", {15'h0000, host.acked}, 16'h0000);
        check("base_port", peripheral_base, 16'hb123);
        rd(24'h0000f2, 16'hb123);
        // a foreign device answering inside the window on purpose
        wr(24'h0000f4, 2'b11, 16'h0002);
        ext_answer <= 1'b1;
        probe(24'h123456, 3'h5, 1'b1, 4'hf);
        check("bus_error_signal", {15'h0000, host.bus_error_signal_seen}, 16'h0001);
        rd(24'h0000f4, 16'h0003);
        wr(24'h0000f4, 2'b11, 16'h0001);
        rd(24'h0000f4, 16'h0000);
        probe(24'h123456, 3'h5, 1'b1, 4'hf);
        check("bus_error_signal", {15'h0000, host.bus_error_signal_seen}, 16'h0000);
        rd(24'h0000f4, 16'h0001);
        ext_answer <= 1'b0;
        wr(24'h0000fa, 2'b11, 16'h00a5);
        pins(1'b0, 1'b1);
        check("base_port", peripheral_base, 16'hb123);
        check("clkctl", clock_control, 16'h00a5);
        pins(1'b0, 1'b0);
        check("base_port", peripheral_base, 16'hbfff);
        check("clkctl", clock_control, 16'h0000);
        probe(24'h123456, 3'h5, 1'b0, 4'hd);
        bus_8bit <= 1'b1;
        wr(24'h0000f2, 2'b10, 16'ha100);
        probe(24'h1ff010, 3'h5, 1'b0, 4'hd);
        wr(24'h0000f2, 2'b01, 16'h0023);
        probe(24'h123456, 3'h5, 1'b1, 4'hf);
        wrap_up();
    end
endmodule
`default_nettype wire
